// *** hw/bcd_opdec.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcd_opdec #(
	parameter bit OPT_SUPPORT    = 1'b1,
	parameter bit WBUF_REMOVABLE = 1'b1
) (
	input  wire logic [7:0]        op_i,
	input  wire logic              removable_i,
	input  wire logic              fmt_sup_i,
	output bcd_pkg::bcd_class_t    cls_o
);

	// Sort an operation code into the class that handles it
	always_comb begin
		case (op_i)
			bcd_pkg::OP_TUR, bcd_pkg::OP_INQ, bcd_pkg::OP_MSEL, bcd_pkg::OP_MSENSE,
			bcd_pkg::OP_SSU, bcd_pkg::OP_WRITE10, bcd_pkg::OP_VERIFY: begin
				cls_o = bcd_pkg::BCD_CL_FWD;
			end
			bcd_pkg::OP_READ10: begin
				cls_o = bcd_pkg::BCD_CL_READ;
			end
			bcd_pkg::OP_RCAP: begin
				cls_o = bcd_pkg::BCD_CL_RCAP;
			end
			bcd_pkg::OP_PREVENT: begin
				cls_o = removable_i ? bcd_pkg::BCD_CL_FWD : bcd_pkg::BCD_CL_BAD;
			end
			bcd_pkg::OP_WBUF: begin
				cls_o = (!removable_i || WBUF_REMOVABLE) ? bcd_pkg::BCD_CL_FWD
				        : bcd_pkg::BCD_CL_BAD;
			end
			bcd_pkg::OP_FORMAT: begin
				cls_o = fmt_sup_i ? bcd_pkg::BCD_CL_FORMAT : bcd_pkg::BCD_CL_BAD;
			end
			bcd_pkg::OP_PRIN, bcd_pkg::OP_PROUT, bcd_pkg::OP_RSV, bcd_pkg::OP_REL,
			bcd_pkg::OP_RSENSE, bcd_pkg::OP_SYNC: begin
				cls_o = OPT_SUPPORT ? bcd_pkg::BCD_CL_FWD : bcd_pkg::BCD_CL_BAD;
			end
			default: begin
				cls_o = bcd_pkg::BCD_CL_BAD;
			end
		endcase
	end

endmodule
`default_nettype wire

// *** hw/bcd_pkg.sv ***
package bcd_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] ADR_CDB0    = 8'h00;
	localparam logic [7:0] ADR_CDB1    = 8'h04;
	localparam logic [7:0] ADR_CDB2    = 8'h08;
	localparam logic [7:0] ADR_CTRL    = 8'h0c;
	localparam logic [7:0] ADR_STAT    = 8'h10;
	localparam logic [7:0] ADR_SENSE   = 8'h14;
	localparam logic [7:0] ADR_INFO    = 8'h18;
	localparam logic [7:0] ADR_CAPLBA  = 8'h1c;
	localparam logic [7:0] ADR_CAPBLEN = 8'h20;

	// Control and status bit positions
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_REMOV_BIT  = 1;
	localparam int CTRL_MEDIUM_BIT = 2;
	localparam int CTRL_FMTSUP_BIT = 3;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_FWD_BIT    = 2;
	localparam int STAT_FMT_BIT    = 3;
	localparam int STAT_CODE_LSB   = 8;

	// Format flag bits, found in descriptor byte 2
	localparam int FL_IMMED_BIT = 0;
	localparam int FL_PROG_BIT  = 1;
	localparam int FL_PTIME_BIT = 2;
	localparam int FL_INCR_BIT  = 3;

	// Operation codes
	localparam logic [7:0] OP_TUR     = 8'h00;
	localparam logic [7:0] OP_RSENSE  = 8'h03;
	localparam logic [7:0] OP_FORMAT  = 8'h04;
	localparam logic [7:0] OP_INQ     = 8'h12;
	localparam logic [7:0] OP_MSEL    = 8'h15;
	localparam logic [7:0] OP_RSV     = 8'h16;
	localparam logic [7:0] OP_REL     = 8'h17;
	localparam logic [7:0] OP_MSENSE  = 8'h1a;
	localparam logic [7:0] OP_SSU     = 8'h1b;
	localparam logic [7:0] OP_PREVENT = 8'h1e;
	localparam logic [7:0] OP_RCAP    = 8'h25;
	localparam logic [7:0] OP_READ10  = 8'h28;
	localparam logic [7:0] OP_WRITE10 = 8'h2a;
	localparam logic [7:0] OP_VERIFY  = 8'h2f;
	localparam logic [7:0] OP_SYNC    = 8'h35;
	localparam logic [7:0] OP_WBUF    = 8'h3b;
	localparam logic [7:0] OP_PRIN    = 8'h5e;
	localparam logic [7:0] OP_PROUT   = 8'h5f;

	// Status bytes, sense keys and additional sense codes
	localparam logic [7:0] ST_GOOD       = 8'h00;
	localparam logic [7:0] ST_CHECK      = 8'h02;
	localparam logic [3:0] SK_NONE       = 4'h0;
	localparam logic [3:0] SK_NOT_READY  = 4'h2;
	localparam logic [3:0] SK_MEDIUM     = 4'h3;
	localparam logic [3:0] SK_ILLEGAL    = 4'h5;
	localparam logic [3:0] SK_UA         = 4'h6;
	localparam logic [7:0] ASC_NOT_READY = 8'h04;
	localparam logic [7:0] ASCQ_FMT_PROG = 8'h04;
	localparam logic [7:0] ASCQ_NO_MED   = 8'h00;
	localparam logic [7:0] ASC_EVENT     = 8'h38;
	localparam logic [7:0] ASCQ_MEDIA_EV = 8'h04;
	localparam logic [7:0] EV_NEW_MEDIA  = 8'h02;
	localparam logic [7:0] ASC_FMT_FAIL  = 8'h31;
	localparam logic [7:0] ASCQ_FMT_FAIL = 8'h01;
	localparam logic [7:0] ASC_LBA_RANGE = 8'h21;
	localparam logic [7:0] ASCQ_LBA_RNG  = 8'h00;
	localparam logic [7:0] ASC_BAD_OP    = 8'h20;
	localparam logic [7:0] ASCQ_BAD_OP   = 8'h00;

	// Progress steps and timing
	localparam logic [2:0] STEP_COARSE = 3'h5;
	localparam logic [2:0] STEP_FINE   = 3'h1;
	localparam logic [6:0] PCT_FULL    = 7'h64;
	localparam int         CLK_HZ      = 100000000;
	localparam int         SEC_TIME_S  = 1;
	localparam int         SEC_CYCLES  = CLK_HZ * SEC_TIME_S;

	// Reset values of the capacity registers
	localparam logic [31:0] CAP_LBA_RST  = 32'h0000_0000;
	localparam logic [31:0] CAP_BLEN_RST = 32'h0000_0200;

	typedef enum logic [2:0] {
		BCD_CL_BAD, BCD_CL_FWD, BCD_CL_FORMAT, BCD_CL_READ, BCD_CL_RCAP
	} bcd_class_t;

	typedef enum logic [2:0] {
		BCD_IDLE, BCD_RD_REQ, BCD_RD_WAIT, BCD_CAP
	} bcd_state_t;

endpackage

// *** hw/bcd_top.sv ***
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Decode mandatory and optional operation codes of the command set.
// - Medium removal only on removable media; write buffer mandatory when fixed.
// - Early-status flag returns status after validation, else after completion.
// - Progress reports only when the progress flag is set.
// - Unit select picks elapsed seconds or percent complete.
// - Granularity flag picks steps of five or one unit.
// - Progress report carries check condition, not ready, 04h/04h.
// - Progress report info holds increments elapsed since command start.
// - Format success gives unit attention 38h/04h, event new media ready.
// - Format failure gives medium error 31h/01h.
// - During format every new command gets the progress report answer.
// - Read fetches the latest contents of each addressed block.
// - Read start block is bytes 2 to 5, most significant first.
// - Read count is bytes 7 and 8; zero moves nothing, no error.
// - Capacity opcode 25h with reserved bytes answers current capacity.
// - Capacity data is sent fully before good status.
// - Capacity data is last block address then block length, big endian.
// - Capacity with no medium gives not ready with code 04h.
// - Access beyond capacity gives illegal request 21h/00h; only reads are checked here, writes and verifies are forwarded.
module bcd_top #(
	parameter int SEC_CYCLES     = bcd_pkg::SEC_CYCLES,
	parameter bit OPT_SUPPORT    = 1'b1,
	parameter bit WBUF_REMOVABLE = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             med_req_o,
	output logic      [31:0] med_lba_o,
	input  wire logic        med_ack_i,
	output logic      [7:0]  out_data_o,
	output logic             out_valid_o,
	input  wire logic        out_ready_i,
	output logic             fmt_busy_o,
	output logic             prog_rpt_o,
	input  wire logic        fmt_pct_tick_i,
	input  wire logic        fmt_fail_i
);

	// Refuse a second length that the prescaler cannot count
	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 2");
	end

	bcd_pkg::bcd_state_t st_q, st_d;
	bcd_pkg::bcd_class_t cls;
	logic [31:0] cdb0_q, cdb0_d, cdb1_q, cdb1_d, cdb2_q, cdb2_d;
	logic        remov_q, remov_d, medium_q, medium_d, fmtsup_q, fmtsup_d;
	logic [31:0] cap_lba_q, cap_lba_d, cap_blen_q, cap_blen_d;
	logic        start_q, start_d, ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [7:0]  status_q, status_d, asc_q, asc_d, ascq_q, ascq_d;
	logic [3:0]  skey_q, skey_d;
	logic [31:0] info_q, info_d, lba_q, lba_d;
	logic [15:0] left_q, left_d, incs_q, incs_d;
	logic        done_q, done_d, fwd_q, fwd_d, req_q, req_d;
	logic [2:0]  idx_q, idx_d, sub_q, sub_d;
	logic        ov_q, ov_d, rpt_q, rpt_d;
	logic [7:0]  od_q, od_d;
	logic        fmt_q, fmt_d, prog_q, prog_d, ptime_q, ptime_d, incr_q, incr_d;
	logic [31:0] pre_q, pre_d;
	logic [6:0]  pct_q, pct_d;
	logic        wr_en, sec_tick, unit_ev, fmt_done, fmt_ev;
	logic [31:0] cmd_lba;
	logic [15:0] cmd_len;
	logic [32:0] last_blk;
	logic [7:0]  flags;
	logic [63:0] cap_bytes;

	// Merge write data into a register under the byte enables
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	bcd_opdec #(
		.OPT_SUPPORT   (OPT_SUPPORT),
		.WBUF_REMOVABLE(WBUF_REMOVABLE)
	) u_dec (
		.op_i       (cdb0_q[7:0]),
		.removable_i(remov_q),
		.fmt_sup_i  (fmtsup_q),
		.cls_o      (cls)
	);

	// Descriptor fields; byte 0 sits in the low lane of the first word
	assign cmd_lba   = {cdb0_q[23:16], cdb0_q[31:24], cdb1_q[7:0], cdb1_q[15:8]};
	assign cmd_len   = {cdb1_q[31:24], cdb2_q[7:0]};
	assign flags     = cdb0_q[23:16];
	assign last_blk  = {1'b0, cmd_lba} + {17'h0_0000, cmd_len} - 33'h0_0000_0001;
	assign cap_bytes = {cap_lba_q, cap_blen_q};
	assign wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

	// Bus slave: one wait state, reads registered, unmapped reads zero
	always_comb begin
		ack_d    = wb_cyc_i && wb_stb_i && !ack_q;
		dat_d    = 32'h0000_0000;
		cdb0_d   = cdb0_q;
		cdb1_d   = cdb1_q;
		cdb2_d   = cdb2_q;
		remov_d  = remov_q;
		medium_d = medium_q;
		fmtsup_d = fmtsup_q;
		cap_lba_d  = cap_lba_q;
		cap_blen_d = cap_blen_q;
		start_d  = 1'b0;
		case (wb_adr_i)
			bcd_pkg::ADR_CDB0:    dat_d = cdb0_q;
			bcd_pkg::ADR_CDB1:    dat_d = cdb1_q;
			bcd_pkg::ADR_CDB2:    dat_d = {16'h0000, cdb2_q[15:0]};
			bcd_pkg::ADR_CTRL:    dat_d = {28'h000_0000, fmtsup_q, medium_q, remov_q, 1'b0};
			bcd_pkg::ADR_STAT:    dat_d = {16'h0000, status_q, 4'h0, fmt_q, fwd_q, done_q,
			                               st_q != bcd_pkg::BCD_IDLE};
			bcd_pkg::ADR_SENSE:   dat_d = {ascq_q, asc_q, 12'h000, skey_q};
			bcd_pkg::ADR_INFO:    dat_d = info_q;
			bcd_pkg::ADR_CAPLBA:  dat_d = cap_lba_q;
			bcd_pkg::ADR_CAPBLEN: dat_d = cap_blen_q;
			default:              dat_d = 32'h0000_0000;
		endcase
		if (wr_en) begin
			case (wb_adr_i)
				bcd_pkg::ADR_CDB0:    cdb0_d = merge(cdb0_q, wb_dat_i, wb_sel_i);
				bcd_pkg::ADR_CDB1:    cdb1_d = merge(cdb1_q, wb_dat_i, wb_sel_i);
				bcd_pkg::ADR_CDB2:    cdb2_d = merge(cdb2_q, wb_dat_i & 32'h0000_ffff,
				                                     {2'b00, wb_sel_i[1:0]});
				bcd_pkg::ADR_CAPLBA:  cap_lba_d = merge(cap_lba_q, wb_dat_i, wb_sel_i);
				bcd_pkg::ADR_CAPBLEN: cap_blen_d = merge(cap_blen_q, wb_dat_i, wb_sel_i);
				bcd_pkg::ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						start_d  = wb_dat_i[bcd_pkg::CTRL_START_BIT];
						remov_d  = wb_dat_i[bcd_pkg::CTRL_REMOV_BIT];
						medium_d = wb_dat_i[bcd_pkg::CTRL_MEDIUM_BIT];
						fmtsup_d = wb_dat_i[bcd_pkg::CTRL_FMTSUP_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Bus slave registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			cdb0_q <= 32'h0000_0000;
			cdb1_q <= 32'h0000_0000;
			cdb2_q <= 32'h0000_0000;
			remov_q <= 1'b0;
			medium_q <= 1'b0;
			fmtsup_q <= 1'b0;
			cap_lba_q <= bcd_pkg::CAP_LBA_RST;
			cap_blen_q <= bcd_pkg::CAP_BLEN_RST;
			start_q <= 1'b0;
		end else if (ce_i) begin
			ack_q <= ack_d;
			dat_q <= dat_d;
			cdb0_q <= cdb0_d;
			cdb1_q <= cdb1_d;
			cdb2_q <= cdb2_d;
			remov_q <= remov_d;
			medium_q <= medium_d;
			fmtsup_q <= fmtsup_d;
			cap_lba_q <= cap_lba_d;
			cap_blen_q <= cap_blen_d;
			start_q <= start_d;
		end
	end

	// Format timing events
	assign sec_tick = fmt_q && (pre_q == 32'(SEC_CYCLES - 1));
	assign unit_ev  = ptime_q ? fmt_pct_tick_i : sec_tick;
	assign fmt_done = fmt_q && fmt_pct_tick_i && (pct_q == bcd_pkg::PCT_FULL - 7'h01);
	assign fmt_ev   = fmt_q && (fmt_fail_i || fmt_done || unit_ev);

	// Command sequencer, format engine and sense results
	always_comb begin
		st_d = st_q;
		status_d = status_q;
		skey_d = skey_q;
		asc_d = asc_q;
		ascq_d = ascq_q;
		info_d = info_q;
		done_d = done_q;
		fwd_d = fwd_q;
		lba_d = lba_q;
		left_d = left_q;
		req_d = req_q;
		idx_d = idx_q;
		ov_d = ov_q;
		od_d = od_q;
		rpt_d = 1'b0;
		fmt_d = fmt_q;
		prog_d = prog_q;
		ptime_d = ptime_q;
		incr_d = incr_q;
		pre_d = fmt_q ? (sec_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001) : 32'h0000_0000;
		pct_d = pct_q;
		sub_d = sub_q;
		incs_d = incs_q;
		case (st_q)
			bcd_pkg::BCD_IDLE: begin
				if (start_q) begin
					done_d = 1'b1;
					fwd_d = 1'b0;
					status_d = bcd_pkg::ST_GOOD;
					skey_d = bcd_pkg::SK_NONE;
					asc_d = 8'h00;
					ascq_d = 8'h00;
					info_d = 32'h0000_0000;
					if (fmt_q) begin
						status_d = bcd_pkg::ST_CHECK;
						skey_d = bcd_pkg::SK_NOT_READY;
						asc_d = bcd_pkg::ASC_NOT_READY;
						ascq_d = bcd_pkg::ASCQ_FMT_PROG;
						info_d = {16'h0000, incs_q};
					end else begin
						case (cls)
							bcd_pkg::BCD_CL_FWD: begin
								fwd_d = 1'b1;
							end
							bcd_pkg::BCD_CL_FORMAT: begin
								fmt_d = 1'b1;
								prog_d = flags[bcd_pkg::FL_PROG_BIT];
								ptime_d = flags[bcd_pkg::FL_PTIME_BIT];
								incr_d = flags[bcd_pkg::FL_INCR_BIT];
								pct_d = 7'h00;
								sub_d = 3'h0;
								incs_d = 16'h0000;
								done_d = flags[bcd_pkg::FL_IMMED_BIT];
							end
							bcd_pkg::BCD_CL_READ, bcd_pkg::BCD_CL_RCAP: begin
								if (!medium_q) begin
									status_d = bcd_pkg::ST_CHECK;
									skey_d = bcd_pkg::SK_NOT_READY;
									asc_d = bcd_pkg::ASC_NOT_READY;
									ascq_d = bcd_pkg::ASCQ_NO_MED;
								end else if (cls == bcd_pkg::BCD_CL_RCAP) begin
									done_d = 1'b0;
									idx_d = 3'h0;
									ov_d = 1'b1;
									od_d = cap_bytes[63:56];
									st_d = bcd_pkg::BCD_CAP;
								end else if (cmd_len == 16'h0000) begin
									done_d = 1'b1;
								end else if (last_blk > {1'b0, cap_lba_q}) begin
									status_d = bcd_pkg::ST_CHECK;
									skey_d = bcd_pkg::SK_ILLEGAL;
									asc_d = bcd_pkg::ASC_LBA_RANGE;
									ascq_d = bcd_pkg::ASCQ_LBA_RNG;
								end else begin
									done_d = 1'b0;
									lba_d = cmd_lba;
									left_d = cmd_len;
									st_d = bcd_pkg::BCD_RD_REQ;
								end
							end
							default: begin
								status_d = bcd_pkg::ST_CHECK;
								skey_d = bcd_pkg::SK_ILLEGAL;
								asc_d = bcd_pkg::ASC_BAD_OP;
								ascq_d = bcd_pkg::ASCQ_BAD_OP;
							end
						endcase
					end
				end
			end
			bcd_pkg::BCD_RD_REQ: begin
				req_d = 1'b1;
				st_d = bcd_pkg::BCD_RD_WAIT;
			end
			bcd_pkg::BCD_RD_WAIT: begin
				if (med_ack_i) begin
					req_d = 1'b0;
					lba_d = lba_q + 32'h0000_0001;
					left_d = left_q - 16'h0001;
					if (left_q == 16'h0001) begin
						done_d = 1'b1;
						st_d = bcd_pkg::BCD_IDLE;
					end else begin
						st_d = bcd_pkg::BCD_RD_REQ;
					end
				end
			end
			bcd_pkg::BCD_CAP: begin
				if (out_ready_i) begin
					idx_d = idx_q + 3'h1;
					od_d = cap_bytes[{3'(3'h6 - idx_q), 3'h0} +: 8]; // Wraps harmlessly at the end
					if (idx_q == 3'h7) begin
						ov_d = 1'b0;
						done_d = 1'b1;
						st_d = bcd_pkg::BCD_IDLE;
					end
				end
			end
			default: begin
				st_d = bcd_pkg::BCD_IDLE;
			end
		endcase
		// Format progress runs beside the sequencer and wins the sense registers
		if (fmt_q && fmt_pct_tick_i) begin
			pct_d = pct_q + 7'h01;
		end
		if (fmt_q && unit_ev && !fmt_done && !fmt_fail_i) begin
			if (sub_q == (incr_q ? bcd_pkg::STEP_FINE : bcd_pkg::STEP_COARSE) - 3'h1) begin
				sub_d = 3'h0;
				incs_d = incs_q + 16'h0001;
				if (prog_q) begin
					rpt_d = 1'b1;
					status_d = bcd_pkg::ST_CHECK;
					skey_d = bcd_pkg::SK_NOT_READY;
					asc_d = bcd_pkg::ASC_NOT_READY;
					ascq_d = bcd_pkg::ASCQ_FMT_PROG;
					info_d = {16'h0000, incs_q + 16'h0001};
				end
			end else begin
				sub_d = sub_q + 3'h1;
			end
		end
		if (fmt_q && fmt_fail_i) begin
			fmt_d = 1'b0;
			done_d = 1'b1;
			status_d = bcd_pkg::ST_CHECK;
			skey_d = bcd_pkg::SK_MEDIUM;
			asc_d = bcd_pkg::ASC_FMT_FAIL;
			ascq_d = bcd_pkg::ASCQ_FMT_FAIL;
			info_d = 32'h0000_0000;
		end else if (fmt_done) begin
			fmt_d = 1'b0;
			done_d = 1'b1;
			status_d = bcd_pkg::ST_CHECK;
			skey_d = bcd_pkg::SK_UA;
			asc_d = bcd_pkg::ASC_EVENT;
			ascq_d = bcd_pkg::ASCQ_MEDIA_EV;
			info_d = {24'h00_0000, bcd_pkg::EV_NEW_MEDIA};
		end
	end

	// Sequencer and format registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= bcd_pkg::BCD_IDLE;
			status_q <= bcd_pkg::ST_GOOD;
			skey_q <= bcd_pkg::SK_NONE;
			asc_q <= 8'h00;
			ascq_q <= 8'h00;
			info_q <= 32'h0000_0000;
			done_q <= 1'b0;
			fwd_q <= 1'b0;
			lba_q <= 32'h0000_0000;
			left_q <= 16'h0000;
			req_q <= 1'b0;
			idx_q <= 3'h0;
			ov_q <= 1'b0;
			od_q <= 8'h00;
			rpt_q <= 1'b0;
			fmt_q <= 1'b0;
			prog_q <= 1'b0;
			ptime_q <= 1'b0;
			incr_q <= 1'b0;
			pre_q <= 32'h0000_0000;
			pct_q <= 7'h00;
			sub_q <= 3'h0;
			incs_q <= 16'h0000;
		end else if (ce_i) begin
			st_q <= st_d;
			status_q <= status_d;
			skey_q <= skey_d;
			asc_q <= asc_d;
			ascq_q <= ascq_d;
			info_q <= info_d;
			done_q <= done_d;
			fwd_q <= fwd_d;
			lba_q <= lba_d;
			left_q <= left_d;
			req_q <= req_d;
			idx_q <= idx_d;
			ov_q <= ov_d;
			od_q <= od_d;
			rpt_q <= rpt_d;
			fmt_q <= fmt_d;
			prog_q <= prog_d;
			ptime_q <= ptime_d;
			incr_q <= incr_d;
			pre_q <= pre_d;
			pct_q <= pct_d;
			sub_q <= sub_d;
			incs_q <= incs_d;
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = dat_q;
	assign med_req_o   = req_q;
	assign med_lba_o   = lba_q;
	assign out_valid_o = ov_q;
	assign out_data_o  = od_q;
	assign fmt_busy_o  = fmt_q;
	assign prog_rpt_o  = rpt_q;

	// Checks
	logic take;
	assign take = ce_i && start_q && (st_q == bcd_pkg::BCD_IDLE) && !fmt_q;

	sequence s_cap_last;
		ce_i && ov_q && out_ready_i && (idx_q == 3'h7);
	endsequence
	sequence s_good_done;
		done_q && (status_q == bcd_pkg::ST_GOOD) && (st_q == bcd_pkg::BCD_IDLE) && !ov_q;
	endsequence

	property p_bad_op;
		@(posedge clk_i) disable iff (rst_i) take && (cls == bcd_pkg::BCD_CL_BAD)
		|=> status_q == bcd_pkg::ST_CHECK && skey_q == bcd_pkg::SK_ILLEGAL && !req_q;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("bad opcode not rejected");

	property p_busy_reply;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && start_q && st_q == bcd_pkg::BCD_IDLE && fmt_q && !fmt_ev
		|=> skey_q == bcd_pkg::SK_NOT_READY && asc_q == 8'h04 && ascq_q == 8'h04 && done_q;
	endproperty
	a_busy_reply: assert property (p_busy_reply) else $error("no progress answer");

	property p_no_report;
		@(posedge clk_i) disable iff (rst_i) fmt_q && !prog_q |=> !rpt_q;
	endproperty
	a_no_report: assert property (p_no_report) else $error("unrequested report");

	property p_report;
		@(posedge clk_i) disable iff (rst_i) rpt_q
		|-> status_q == 8'h02 && skey_q == 4'h2 && asc_q == 8'h04 && ascq_q == 8'h04
		    && info_q == {16'h0000, incs_q};
	endproperty
	a_report: assert property (p_report) else $error("bad progress report");

	property p_complete;
		@(posedge clk_i) disable iff (rst_i) ce_i && fmt_done && !fmt_fail_i
		|=> !fmt_q && skey_q == 4'h6 && asc_q == 8'h38 && ascq_q == 8'h04
		    && info_q[7:0] == 8'h02 && done_q;
	endproperty
	a_complete: assert property (p_complete) else $error("bad completion");

	property p_fail;
		@(posedge clk_i) disable iff (rst_i) ce_i && fmt_q && fmt_fail_i
		|=> !fmt_q && skey_q == 4'h3 && asc_q == 8'h31 && ascq_q == 8'h01;
	endproperty
	a_fail: assert property (p_fail) else $error("bad failure sense");

	property p_immed;
		@(posedge clk_i) disable iff (rst_i) take && cls == bcd_pkg::BCD_CL_FORMAT
		&& !fmt_ev |=> fmt_q && (done_q == $past(flags[bcd_pkg::FL_IMMED_BIT]));
	endproperty
	a_immed: assert property (p_immed) else $error("early status wrong");

	property p_cap_order;
		@(posedge clk_i) disable iff (rst_i) s_cap_last |=> s_good_done;
	endproperty
	a_cap_order: assert property (p_cap_order) else $error("status before data");

	property p_zero_len;
		@(posedge clk_i) disable iff (rst_i) take && cls == bcd_pkg::BCD_CL_READ
		&& medium_q && cmd_len == 16'h0000 && !fmt_ev
		|=> (!req_q && status_q == 8'h00 && done_q) [*2];
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("zero length moved data");

	property p_range;
		@(posedge clk_i) disable iff (rst_i) take && cls == bcd_pkg::BCD_CL_READ
		&& medium_q && cmd_len != 16'h0000 && last_blk > {1'b0, cap_lba_q} && !fmt_ev
		|=> skey_q == 4'h5 && asc_q == 8'h21 && st_q == bcd_pkg::BCD_IDLE;
	endproperty
	a_range: assert property (p_range) else $error("range not checked");

endmodule
`default_nettype wire

// *** verification/bcd_medium.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcd_medium (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic med_req_i,
	output logic      med_ack_o,
	output logic      out_ready_o
);
	logic [2:0] wait_q;
	// Medium acks each block after a wait; byte sink stalls every other cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_q      <= 3'h0;
			med_ack_o   <= 1'b0;
			out_ready_o <= 1'b0;
		end else begin
			out_ready_o <= ~out_ready_o;
			med_ack_o   <= med_req_i && !med_ack_o && wait_q == 3'h7;
			wait_q      <= (med_req_i && !med_ack_o) ? wait_q + 3'h1 : wait_q;
		end
	end
endmodule
`default_nettype wire

// *** verification/test_block_cmd_decoder_format_read.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_block_cmd_decoder_format_read;
	logic        clk_i, rst_i, cyc, stb, we, tick, fail, req, ack, rdy, vld, busy, mack, prog;
	logic [7:0]  adr, od;
	logic [31:0] wdat, rdat, lba, last_lba, s, sn;
	logic [63:0] cap;
	int          n_mismatch, check_count, nack, nrpt, i;
	logic [7:0]  fwd [9] = '{8'h00, 8'h12, 8'h15, 8'h1a, 8'h1b, 8'h2f, 8'h2a, 8'h1e, 8'h3b};
	bcd_top #(.SEC_CYCLES(20)) dut_u (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .med_req_o(req), .med_lba_o(lba), .med_ack_i(mack),
		.out_data_o(od), .out_valid_o(vld), .out_ready_i(rdy), .fmt_busy_o(busy),
		.prog_rpt_o(prog), .fmt_pct_tick_i(tick), .fmt_fail_i(fail));
	bcd_medium med_u (.clk_i, .rst_i, .med_req_i(req), .med_ack_o(mack), .out_ready_o(rdy));
	// Clock, and monitors of block traffic, byte traffic and progress reports
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (req && mack) begin
			nack <= nack + 1;
			last_lba <= lba;
		end
		if (vld && rdy) cap <= {cap[55:0], od};
		if (prog) nrpt <= nrpt + 1;
	end
	task automatic final_report;
		if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Classic single Wishbone cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		s = rdat;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [0:9][7:0] c, input logic [7:0] ct);
		bus(1, bcd_pkg::ADR_CDB0, {c[3], c[2], c[1], c[0]});
		bus(1, bcd_pkg::ADR_CDB1, {c[7], c[6], c[5], c[4]});
		bus(1, bcd_pkg::ADR_CDB2, {16'h0, c[9], c[8]});
		bus(1, bcd_pkg::ADR_CTRL, {24'h0, ct});
	endtask
	// Waits for done, checks the status byte and keeps the sense word
	task automatic res(input logic [7:0] st);
		do bus(0, bcd_pkg::ADR_STAT, 0); while (s[1] !== 1'b1);
		chk({24'h0, s[15:8]}, {24'h0, st});
		bus(0, bcd_pkg::ADR_SENSE, 0);
		sn = s;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1;
			@(posedge clk_i);
			tick <= 0;
			@(posedge clk_i);
		end
	endtask
	// Mode sense then capacity, as the host does after a format ends
	task automatic relearn;
		cmd({8'h1a, 72'h0}, 8'h0f);
		res(bcd_pkg::ST_GOOD);
		cmd({8'h25, 72'h0}, 8'h0f);
		res(bcd_pkg::ST_GOOD);
	endtask
	initial begin
		{cyc, stb, we, tick, fail, adr, wdat, n_mismatch, check_count} = 0;
		rst_i = 1;
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, bcd_pkg::ADR_CAPBLEN, 0);
		chk(s, 32'h200);
		bus(0, 8'hf0, 0);
		chk(s, 0);
		for (i = 0; i < 9; i++) begin
			cmd({fwd[i], 72'h0}, 8'h0f);
			res(bcd_pkg::ST_GOOD);
			bus(0, bcd_pkg::ADR_STAT, 0);
			chk(s & 32'h4, 32'h4);
		end
		cmd({8'h1e, 72'h0}, 8'h0d);
		res(bcd_pkg::ST_CHECK);
		cmd({8'hc0, 72'h0}, 8'h0f);
		res(bcd_pkg::ST_CHECK);
		chk(sn, 32'h0020_0005);
		bus(1, bcd_pkg::ADR_CAPLBA, 32'h01020304);
		cmd(80'h25_ff_ffffffff_ffffff_00, 8'h0f);
		res(bcd_pkg::ST_GOOD);
		chk(cap[63:32], 32'h01020304);
		chk(cap[31:0], 32'h200);
		cmd(80'h25_00_00000000_000000_00, 8'h0b);
		res(bcd_pkg::ST_CHECK);
		chk(sn, 32'h0004_0002);
		cmd(80'h28_00_00000010_00_0002_00, 8'h0f);
		res(bcd_pkg::ST_GOOD);
		chk(last_lba, 32'h11);
		cmd(80'h28_00_00000010_00_0000_00, 8'h0f);
		res(bcd_pkg::ST_GOOD);
		chk(nack, 2);
		cmd(80'h28_00_70000000_00_0001_00, 8'h0f);
		res(bcd_pkg::ST_CHECK);
		chk(sn, 32'h0021_0005);
		bus(0, bcd_pkg::ADR_CTRL, 0);
		chk(s & 32'h8, 32'h8);
		cmd({32'h04_00_0f_00, 48'h0}, 8'h0f);
		res(bcd_pkg::ST_GOOD);
		ticks(3);
		bus(0, bcd_pkg::ADR_INFO, 0);
		chk(s, 3);
		cmd(80'h28_00_00000010_00_0001_00, 8'h0f);
		res(bcd_pkg::ST_CHECK);
		chk(sn, 32'h0404_0002);
		chk(nack, 2);
		ticks(97);
		bus(0, bcd_pkg::ADR_SENSE, 0);
		chk(s, 32'h0438_0006);
		bus(0, bcd_pkg::ADR_INFO, 0);
		chk({s[31:1], busy}, 2);
		chk(nrpt, 99);
		relearn();
		cmd({32'h04_00_02_00, 48'h0}, 8'h0f);
		repeat (110) @(posedge clk_i);
		bus(0, bcd_pkg::ADR_STAT, 0);
		chk({31'h0, s[1]}, 0);
		bus(0, bcd_pkg::ADR_INFO, 0);
		chk(s, 1);
		fail <= 1;
		@(posedge clk_i);
		fail <= 0;
		res(bcd_pkg::ST_CHECK);
		chk(sn, 32'h0131_0003);
		relearn();
		cmd({32'h04_00_00_00, 48'h0}, 8'h0f);
		repeat (110) @(posedge clk_i);
		chk(nrpt, 100);
		final_report();
	end
	initial begin
		#500us;
		n_mismatch++;
		final_report();
	end
endmodule
`default_nettype wire
